//--- mmd_decoder.sv
// memory map decoder: cpu address to region select, with axi4-lite size registers
`timescale 1ns/100ps
`include "mmd_regs.svh"
module mmd_decoder #(
  parameter int BANK_COUNT = 6,
  parameter bit DEBUG_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // cpu request
  input wire mmd_pkg::mmd_cpu_req_t cpu_req,
  // region routing and registered size codes
  output mmd_pkg::mmd_route_t route_ff,
  output logic [7:0] mem_size_out_ff,
  output logic [7:0] xram_size_out_ff,
  // axi4-lite write address
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_awaddr,
  input wire logic [2:0] s_awprot,
  // axi4-lite write data
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  // axi4-lite write response
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // axi4-lite read address
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [31:0] s_araddr,
  input wire logic [2:0] s_arprot,
  // axi4-lite read data
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp
);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  logic [7:0] mem_size;
  logic [7:0] xram_size;
  logic [7:0] ctrl;
  logic [7:0] cfg_rd;
  logic aw_held_ff;
  logic w_held_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rpend_ff;
  logic rvalid_ff;
  logic [31:0] araddr_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  mmd_pkg::mmd_wr_state_t wr_state_ff;
  logic wr_fire;
  logic wr_ok;
  logic [1:0] wr_idx;
  logic [2:0] wr_code;
  logic [2:0] rd_code;
  logic [1:0] rd_idx;
  logic [7:0] bc0_block_cnt_ff;
  mmd_pkg::mmd_route_t nxt_route;

  // register index from byte address, 3'h3 for the status word, 3'h7 for unmapped
  function automatic logic [2:0] reg_index(input logic [31:0] a);
    logic [2:0] r;
    r = 3'h7;
    if (a[31:4] == 28'h0000000 && a[1:0] == 2'b00) begin
      r = {1'b0, a[3:2]};
    end
    return r;
  endfunction

  // size code to top flash address, zero if invalid
  function automatic logic [15:0] rom_end(input logic [7:0] code);
    logic [15:0] e;
    e = 16'h0000;
    unique case (code)
      `MMD_MS_16K: e = `MMD_ROM_16K_END;
      `MMD_MS_24K: e = `MMD_ROM_24K_END;
      `MMD_MS_32K: e = `MMD_ROM_32K_END;
      `MMD_MS_48K: e = `MMD_ROM_48K_END;
      `MMD_MS_60K: e = `MMD_ROM_60K_END;
      default: e = 16'h0000;
    endcase
    return e;
  endfunction

  // size code to expansion ram base, ffffh none
  function automatic logic [15:0] xram_lo(input logic [7:0] code);
    logic [15:0] b;
    b = 16'hffff;
    unique case (code)
      `MMD_XS_1K: b = `MMD_XRAM_1K_LO;
      `MMD_XS_2K: b = `MMD_XRAM_2K_LO;
      `MMD_XS_4K: b = `MMD_XRAM_4K_LO;
      `MMD_XS_6K: b = `MMD_XRAM_6K_LO;
      default: b = 16'hffff;
    endcase
    return b;
  endfunction

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  mmd_cfg_regs #(
    .MEM_RST(`MMD_MEM_SIZE_RST),
    .XRAM_RST(`MMD_XRAM_SIZE_RST)
  ) u_cfg (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_ok),
    .wr_idx(wr_idx),
    .wr_data(wdata_ff[7:0]),
    .rd_idx(rd_idx),
    .rd_data_ff(cfg_rd),
    .mem_size_ff(mem_size),
    .xram_size_ff(xram_size),
    .ctrl_ff(ctrl)
  );

  // write channel capture, either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 32'h00000000;
    end else if (s_awvalid && s_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (s_wvalid && s_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_wdata;
      wstrb_ff <= s_wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  assign s_awready = !aw_held_ff && wr_state_ff == mmd_pkg::MMD_WR_IDLE;
  assign s_wready = !w_held_ff && wr_state_ff == mmd_pkg::MMD_WR_IDLE;
  assign wr_fire = aw_held_ff && w_held_ff && wr_state_ff == mmd_pkg::MMD_WR_IDLE;
  assign wr_code = reg_index(awaddr_ff);
  assign rd_code = reg_index(araddr_ff);
  assign wr_idx = wr_code[1:0];
  // store is read on the address edge so data is fresh one edge later
  assign rd_idx = (s_arvalid && s_arready) ? s_araddr[3:2] : araddr_ff[3:2];
  // status word and unmapped addresses are not writable
  assign wr_ok = wr_fire && !wr_code[2] && wr_idx != 2'h3 && wstrb_ff[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_state_ff <= mmd_pkg::MMD_WR_IDLE;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      unique case (wr_state_ff)
        mmd_pkg::MMD_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_ff <= mmd_pkg::MMD_WR_RESP;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_code[2] ? RESP_SLVERR : RESP_OKAY;
          end
        end
        mmd_pkg::MMD_WR_RESP: begin
          if (s_bready) begin
            wr_state_ff <= mmd_pkg::MMD_WR_IDLE;
            bvalid_ff <= 1'b0;
          end
        end
        default: wr_state_ff <= mmd_pkg::MMD_WR_IDLE;
      endcase
    end
  end

  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;

  // read: capture address, one cycle for the registered store, then answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rpend_ff <= 1'b0;
      araddr_ff <= 32'h00000000;
    end else if (s_arvalid && s_arready) begin
      rpend_ff <= 1'b1;
      araddr_ff <= s_araddr;
    end else begin
      rpend_ff <= 1'b0;
    end
  end

  assign s_arready = !rpend_ff && !rvalid_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (rpend_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_code[2] ? RESP_SLVERR : RESP_OKAY;
      if (rd_code[2]) begin
        rdata_ff <= 32'h00000000;
      end else if (araddr_ff[3:2] == 2'h3) begin
        rdata_ff <= {16'h0000, bc0_block_cnt_ff, 4'h0, route_ff.region};
      end else begin
        rdata_ff <= {24'h000000, cfg_rd};
      end
    end else if (rvalid_ff && s_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;

  // address decode of one cpu access
  always_comb begin
    logic [15:0] a;
    logic [15:0] rend;
    logic [15:0] xlo;
    logic [15:0] hs_lo;
    logic swap;
    logic [2:0] bank;
    a = cpu_req.addr;
    rend = rom_end(mem_size);
    xlo = xram_lo(xram_size);
    // smallest size trades high-speed ram down to 736 bytes
    hs_lo = (mem_size == `MMD_MS_16K) ? `MMD_HSRAM_SMALL_LO : `MMD_HSRAM_LO;
    swap = ctrl[`MMD_CTRL_BOOT_SWAP];
    bank = ctrl[`MMD_CTRL_BANK_LSB +: `MMD_CTRL_BANK_W];
    nxt_route = '0;
    nxt_route.region = mmd_pkg::MMD_RG_NONE;
    // full 16-bit space, one decode for code and data except working registers, where fetches map to none
    if (!cpu_req.valid) begin
      nxt_route.region = mmd_pkg::MMD_RG_NONE;
    end else if (a >= `MMD_SFR_LO) begin
      nxt_route.region = mmd_pkg::MMD_RG_SFR;
    end else if (a >= `MMD_GPR_LO) begin
      nxt_route.region = cpu_req.fetch ? mmd_pkg::MMD_RG_NONE : mmd_pkg::MMD_RG_GPR;
    // high-speed ram below the working registers
    end else if (a >= hs_lo) begin
      nxt_route.region = mmd_pkg::MMD_RG_HSRAM;
      nxt_route.ram_addr = 13'(a - hs_lo);
    end else if (xlo != 16'hffff && in_range(a, xlo, `MMD_XRAM_END)) begin
      nxt_route.region = mmd_pkg::MMD_RG_XRAM;
      nxt_route.ram_addr = 13'(a - xlo);
    end else if (rend != 16'h0000 && a <= rend) begin
      nxt_route.flash_addr = {1'b0, a};
      if (a <= `MMD_VEC_END) begin
        nxt_route.region = mmd_pkg::MMD_RG_VECTOR;
      end else if (a <= `MMD_CALL_END) begin
        nxt_route.region = mmd_pkg::MMD_RG_CALL_TABLE;
      // option bytes, cluster 1 copy under boot swap
      end else if (in_range(a, `MMD_OPT_LO, `MMD_OPT_HI)
                   || (swap && in_range(a, `MMD_OPT_LO + `MMD_CLUSTER1_OFS,
                                        `MMD_OPT_HI + `MMD_CLUSTER1_OFS))) begin
        nxt_route.region = mmd_pkg::MMD_RG_OPTION;
      end else if (DEBUG_VARIANT && ctrl[`MMD_CTRL_DEBUG_EN]
                   && (in_range(a, `MMD_DBG_LO, `MMD_DBG_HI)
                       || (swap && in_range(a, `MMD_DBG_LO + `MMD_CLUSTER1_OFS,
                                            `MMD_DBG_HI + `MMD_CLUSTER1_OFS)))) begin
        nxt_route.region = mmd_pkg::MMD_RG_DEBUG_ID;
      end else begin
        nxt_route.region = mmd_pkg::MMD_RG_FLASH;
      end
      // bank window goes to selected bank above common area
      if (BANK_COUNT > 0 && mem_size == `MMD_MS_48K
          && in_range(a, `MMD_BANK_LO, `MMD_BANK_HI)) begin
        if (32'(bank) < BANK_COUNT) begin
          nxt_route.flash_addr = 17'(32'(`MMD_BANK_LO) + 32'(bank) * 32'h4000
                                     + 32'(a[13:0]));
        end else begin
          nxt_route.region = mmd_pkg::MMD_RG_NONE;
        end
      end
      // protected boot cluster 0 refuses writes
      if (cpu_req.write && ctrl[`MMD_CTRL_BC0_PROTECT] && a <= `MMD_BC0_END) begin
        nxt_route.blocked = 1'b1;
        nxt_route.region = mmd_pkg::MMD_RG_NONE;
      end
    end
    // one-hot select from the region code
    if (nxt_route.region != mmd_pkg::MMD_RG_NONE) begin
      nxt_route.sel = 10'(10'h001 << nxt_route.region);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route_ff <= '0;
    end else begin
      route_ff <= nxt_route;
    end
  end

  // blocked write counter, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bc0_block_cnt_ff <= 8'h00;
    end else if (nxt_route.blocked && bc0_block_cnt_ff != 8'hff) begin
      bc0_block_cnt_ff <= bc0_block_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_size_out_ff <= `MMD_MEM_SIZE_RST;
      xram_size_out_ff <= `MMD_XRAM_SIZE_RST;
    end else begin
      mem_size_out_ff <= mem_size;
      xram_size_out_ff <= xram_size;
    end
  end
endmodule

//--- mmd_regs.svh
// offsets, fields, reset values and address bounds of the memory map decoder
`ifndef MMD_REGS_SVH
`define MMD_REGS_SVH
`define MMD_OFF_MEM_SIZE 4'h0
`define MMD_OFF_XRAM_SIZE 4'h4
`define MMD_OFF_CTRL 4'h8
`define MMD_OFF_STATUS 4'hc
`define MMD_MEM_SIZE_RST 8'hcf
`define MMD_XRAM_SIZE_RST 8'h0c
`define MMD_MS_16K 8'h04
`define MMD_MS_24K 8'hc6
`define MMD_MS_32K 8'hc8
`define MMD_MS_48K 8'hcc
`define MMD_MS_60K 8'hcf
`define MMD_XS_NONE 8'h0c
`define MMD_XS_1K 8'h0a
`define MMD_XS_2K 8'h0b
`define MMD_XS_4K 8'h04
`define MMD_XS_6K 8'h00
`define MMD_CTRL_BOOT_SWAP 0
`define MMD_CTRL_BC0_PROTECT 1
`define MMD_CTRL_DEBUG_EN 2
`define MMD_CTRL_BANK_LSB 4
`define MMD_CTRL_BANK_W 3
`define MMD_VEC_END 16'h003f
`define MMD_CALL_END 16'h007f
`define MMD_OPT_LO 16'h0080
`define MMD_OPT_HI 16'h0084
`define MMD_DBG_LO 16'h0085
`define MMD_DBG_HI 16'h008e
`define MMD_CLUSTER1_OFS 16'h1000
`define MMD_BC0_END 16'h0fff
`define MMD_BANK_LO 16'h8000
`define MMD_BANK_HI 16'hbfff
`define MMD_SFR_LO 16'hff00
`define MMD_GPR_LO 16'hfee0
`define MMD_HSRAM_LO 16'hfb00
`define MMD_HSRAM_SMALL_LO 16'hfc00
`define MMD_XRAM_END 16'hf7ff
`define MMD_XRAM_6K_LO 16'he000
`define MMD_XRAM_4K_LO 16'he800
`define MMD_XRAM_2K_LO 16'hf000
`define MMD_XRAM_1K_LO 16'hf400
`define MMD_ROM_16K_END 16'h3fff
`define MMD_ROM_24K_END 16'h5fff
`define MMD_ROM_32K_END 16'h7fff
`define MMD_ROM_48K_END 16'hbfff
`define MMD_ROM_60K_END 16'hefff
`endif

//--- mmd_pkg.sv
// types of the memory map decoder
package mmd_pkg;
  typedef enum logic [3:0] {
    MMD_RG_NONE = 4'h0,
    MMD_RG_VECTOR = 4'h1,
    MMD_RG_CALL_TABLE = 4'h2,
    MMD_RG_OPTION = 4'h3,
    MMD_RG_DEBUG_ID = 4'h4,
    MMD_RG_FLASH = 4'h5,
    MMD_RG_XRAM = 4'h6,
    MMD_RG_HSRAM = 4'h7,
    MMD_RG_GPR = 4'h8,
    MMD_RG_SFR = 4'h9
  } mmd_region_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic [15:0] addr;
  } mmd_cpu_req_t;

  typedef struct packed {
    logic [9:0] sel;
    mmd_region_t region;
    logic [16:0] flash_addr;
    logic [12:0] ram_addr;
    logic blocked;
  } mmd_route_t;

  typedef enum logic [1:0] {
    MMD_WR_IDLE = 2'b00,
    MMD_WR_RESP = 2'b01
  } mmd_wr_state_t;
endpackage

//--- mmd_cfg_regs.sv
// register store for size, control and bank settings
`timescale 1ns/100ps
module mmd_cfg_regs #(
  parameter logic [7:0] MEM_RST = 8'hcf,
  parameter logic [7:0] XRAM_RST = 8'h0c
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // read port, registered
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_data_ff,
  // stored values
  output logic [7:0] mem_size_ff,
  output logic [7:0] xram_size_ff,
  output logic [7:0] ctrl_ff
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_size_ff <= MEM_RST;
      xram_size_ff <= XRAM_RST;
      ctrl_ff <= 8'h00;
    end else if (wr_en) begin
      unique case (wr_idx)
        2'h0: mem_size_ff <= wr_data;
        2'h1: xram_size_ff <= wr_data;
        2'h2: ctrl_ff <= wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
    end else begin
      unique case (rd_idx)
        2'h0: rd_data_ff <= mem_size_ff;
        2'h1: rd_data_ff <= xram_size_ff;
        2'h2: rd_data_ff <= ctrl_ff;
        default: rd_data_ff <= 8'h00;
      endcase
    end
  end
endmodule

//--- mmd_decoder_checker.sv
// assertions on the memory map decoder ports
`timescale 1ns/100ps
module mmd_decoder_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // cpu side
  input wire mmd_pkg::mmd_cpu_req_t cpu_req,
  input wire mmd_pkg::mmd_route_t route_ff,
  input wire logic [7:0] mem_size_out_ff,
  input wire logic [7:0] xram_size_out_ff,
  // register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic v;
  logic [15:0] a;
  assign v = cpu_req.valid;
  assign a = cpu_req.addr;
  sequence s_wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence s_rd_taken;
    s_arvalid && s_arready;
  endsequence
  chk_sel_onehot: assert property (route_ff.sel == 10'(10'h1 << route_ff.region) >> 1 << 1)
    else $error("select not one-hot with region");
  chk_size_reset: assert property ($rose(rst_n) |-> mem_size_out_ff == 8'hcf && xram_size_out_ff == 8'h0c)
    else $error("size registers wrong after reset");
  chk_sfr_decode: assert property (v && a >= 16'hff00 |=> route_ff.region == mmd_pkg::MMD_RG_SFR)
    else $error("sfr access misrouted");
  chk_gpr_decode: assert property (v && !cpu_req.fetch && a >= 16'hfee0 && a <= 16'hfeff
    |=> route_ff.region == mmd_pkg::MMD_RG_GPR)
    else $error("working register access misrouted");
  chk_vector_decode: assert property (v && !cpu_req.write && a <= 16'h003f
    |=> route_ff.region == mmd_pkg::MMD_RG_VECTOR)
    else $error("vector access misrouted");
  chk_call_decode: assert property (v && !cpu_req.write && a >= 16'h0040 && a <= 16'h007f
    |=> route_ff.region == mmd_pkg::MMD_RG_CALL_TABLE)
    else $error("call table access misrouted");
  chk_option_decode: assert property (v && !cpu_req.write && a >= 16'h0080 && a <= 16'h0084
    |=> route_ff.region == mmd_pkg::MMD_RG_OPTION)
    else $error("option byte access misrouted");
  chk_hsram_decode: assert property (v && a >= 16'hfc00 && a <= 16'hfedf
    |=> route_ff.region == mmd_pkg::MMD_RG_HSRAM)
    else $error("high-speed ram access misrouted");
  chk_bank_offset: assert property (v && a[15:14] == 2'b10 |=> route_ff.region != mmd_pkg::MMD_RG_FLASH
    || route_ff.flash_addr[13:0] == $past(a[13:0]))
    else $error("bank window offset wrong");
  chk_blocked_write: assert property (route_ff.blocked |-> $past(cpu_req.write) && $past(a) <= 16'h0fff
    && route_ff.region == mmd_pkg::MMD_RG_NONE)
    else $error("blocked flag without low write");
  chk_write_answer: assert property (s_wr_taken |-> ##[1:3] s_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (s_rd_taken |-> ##[1:3] s_rvalid)
    else $error("read data missing");
endmodule
bind mmd_decoder mmd_decoder_checker u_chk (.clk(clk), .rst_n(rst_n), .cpu_req(cpu_req),
  .route_ff(route_ff), .mem_size_out_ff(mem_size_out_ff), .xram_size_out_ff(xram_size_out_ff),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_bvalid(s_bvalid), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid));

//--- mmd_cpu_model.sv
// cpu core model issuing single accesses
`timescale 1ns/100ps
module mmd_cpu_model (
  // clock
  input wire logic clk,
  // request
  output mmd_pkg::mmd_cpu_req_t cpu_req
);
  initial cpu_req = '0;
  task automatic access(input logic [15:0] a, input logic wr, input logic fe);
    @(posedge clk);
    cpu_req <= {1'b1, wr, fe, a};
    @(posedge clk);
    cpu_req <= {1'b0, 1'b0, 1'b0, ~a};
  endtask
endmodule

//--- memory_map_decoder_tb.sv
// self-checking bench of the memory map decoder
`timescale 1ns/100ps
module memory_map_decoder_tb;
  logic clk, rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, d;
  logic [1:0] s_bresp, s_rresp, r;
  logic [7:0] mem_size_out_ff, xram_size_out_ff, ms, xs, ctl;
  mmd_pkg::mmd_cpu_req_t cpu_req;
  mmd_pkg::mmd_route_t route_ff;
  int bad_count, checks, cyc, seed;
  logic [7:0] ms_tab [7] = '{8'h04, 8'hc6, 8'hc8, 8'hcc, 8'hcf, 8'hcc, 8'hcc};
  logic [7:0] xs_tab [7] = '{8'h0c, 8'h0c, 8'h0c, 8'h0a, 8'h0b, 8'h04, 8'h00};
  logic [15:0] cor [39] = '{16'h0000, 16'h003f, 16'h0040, 16'h007f, 16'h0080, 16'h0084,
    16'h0085, 16'h008e, 16'h008f, 16'h0fff, 16'h1080, 16'h1084, 16'h1085, 16'h108e, 16'h3fff,
    16'h4000, 16'h5fff, 16'h6000, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hdfff, 16'he000,
    16'he800, 16'hefff, 16'hf000, 16'hf400, 16'hf7ff, 16'hf800, 16'hfaff, 16'hfb00, 16'hfbff,
    16'hfc00, 16'hfedf, 16'hfee0, 16'hfeff, 16'hff00, 16'hffff};
  mmd_cpu_model u_cpu (.clk(clk), .cpu_req(cpu_req));
  mmd_decoder #(.BANK_COUNT(6), .DEBUG_VARIANT(1'b1)) dut (.clk(clk), .rst_n(rst_n),
    .cpu_req(cpu_req), .route_ff(route_ff), .mem_size_out_ff(mem_size_out_ff),
    .xram_size_out_ff(xram_size_out_ff), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_awaddr(s_awaddr), .s_awprot(3'h0), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_wdata(s_wdata), .s_wstrb(4'hf), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_bresp(s_bresp), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
    .s_arprot(3'h0), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata),
    .s_rresp(s_rresp));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  task automatic tally_and_finish;
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // ready sampled mid-cycle holds at the next rising edge
  task automatic axi_wr(input logic [7:0] ad, input logic [7:0] dv, output logic [1:0] rs);
    logic aw_t, w_t, b_t;
    @(posedge clk);
    s_awaddr <= {24'h0, ad};
    s_wdata <= {24'h0, dv};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge clk);
      aw_t = s_awvalid && s_awready;
      w_t = s_wvalid && s_wready;
      b_t = s_bvalid;
      rs = s_bresp;
      @(posedge clk);
      if (aw_t) s_awvalid <= 1'b0;
      if (w_t) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dv, output logic [1:0] rs);
    logic ar_t, r_t;
    @(posedge clk);
    s_araddr <= {24'h0, ad};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge clk);
      ar_t = s_arvalid && s_arready;
      r_t = s_rvalid;
      dv = s_rdata;
      rs = s_rresp;
      @(posedge clk);
      if (ar_t) s_arvalid <= 1'b0;
    end
    s_rready <= 1'b0;
  endtask
  function automatic logic [3:0] exp_rg(input logic [15:0] a, input logic wr, input logic fe);
    logic [15:0] rend, xlo, hlo, o;
    rend = ms == 8'h04 ? 16'h3fff : ms == 8'hc6 ? 16'h5fff : ms == 8'hc8 ? 16'h7fff :
      ms == 8'hcc ? 16'hbfff : 16'hefff;
    xlo = xs == 8'h00 ? 16'he000 : xs == 8'h04 ? 16'he800 : xs == 8'h0b ? 16'hf000 :
      xs == 8'h0a ? 16'hf400 : 16'hffff;
    hlo = ms == 8'h04 ? 16'hfc00 : 16'hfb00;
    o = (ctl[0] && a >= 16'h1080 && a <= 16'h108e) ? a - 16'h1000 : a;
    if (a >= 16'hff00) return 4'h9;
    if (a >= 16'hfee0) return fe ? 4'h0 : 4'h8;
    if (a >= hlo) return 4'h7;
    if (a >= xlo && a <= 16'hf7ff) return 4'h6;
    if (a > rend) return 4'h0;
    if (wr && ctl[1] && a <= 16'h0fff) return 4'h0;
    if (a <= 16'h003f) return 4'h1;
    if (a <= 16'h007f) return 4'h2;
    if (o >= 16'h0080 && o <= 16'h0084) return 4'h3;
    if (o >= 16'h0085 && o <= 16'h008e && ctl[2]) return 4'h4;
    if (ms == 8'hcc && a >= 16'h8000 && ctl[6:4] >= 3'd6) return 4'h0;
    return 4'h5;
  endfunction
  task automatic probe(input logic [15:0] a, input logic wr, input logic fe);
    u_cpu.access(a, wr, fe);
    #1;
    chk("region", {28'h0, exp_rg(a, wr, fe)}, {28'h0, route_ff.region});
    chk("blocked", {31'h0, wr && ctl[1] && a <= 16'h0fff}, {31'h0, route_ff.blocked});
    if (ms == 8'hcc && a[15:14] == 2'b10 && ctl[6:4] < 3'd6) begin
      chk("flash_addr", 32'h8000 + ctl[6:4] * 32'h4000 + a[13:0], {15'h0, route_ff.flash_addr});
    end
  endtask
  task automatic cfg(input logic [7:0] m, input logic [7:0] x, input logic [7:0] c);
    axi_wr(8'h00, m, r);
    axi_wr(8'h04, x, r);
    axi_wr(8'h08, c, r);
    ms = m;
    xs = x;
    ctl = c;
    axi_rd(8'h00, d, r);
    chk("memory_size_select", {24'h0, m}, d);
    axi_rd(8'h04, d, r);
    chk("expansion_ram_size_select", {24'h0, x}, d);
    chk("mem_size_out_ff", {24'h0, m}, {24'h0, mem_size_out_ff});
    chk("xram_size_out_ff", {24'h0, x}, {24'h0, xram_size_out_ff});
  endtask
  task automatic sweep;
    logic [15:0] a;
    logic [2:0] k;
    for (int i = 0; i < 70; i++) begin
      a = i < 39 ? cor[i] : 16'($random(seed));
      k = 3'($random(seed));
      probe(a, k[0], k[1] & ~k[0]);
    end
  endtask
  initial begin
    seed = 60;
    {rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_wdata, s_araddr} = '0;
    {bad_count, checks, cyc} = '0;
    ms = 8'hcf;
    xs = 8'h0c;
    ctl = 8'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(8'h00, d, r);
    chk("memory_size_select", 32'hcf, d);
    axi_rd(8'h04, d, r);
    chk("expansion_ram_size_select", 32'h0c, d);
    axi_rd(8'h10, d, r);
    chk("rresp", 32'h2, {30'h0, r});
    axi_wr(8'h10, 8'h55, r);
    chk("bresp", 32'h2, {30'h0, r});
    sweep();
    for (int i = 0; i < 7; i++) begin
      cfg(ms_tab[i], xs_tab[i], 8'h00);
      sweep();
    end
    for (int i = 0; i < 8; i++) begin
      cfg(8'hcc, 8'h00, {1'b0, 3'(i), 1'b0, 3'(i)});
      sweep();
    end
    tally_and_finish();
  end
endmodule
